/* File: src/ssc_pkg.sv */
// package: register map, field layouts and carriers of the navigation sample capture
package ssc_pkg;

  // register byte offsets on the slave port
  localparam logic [7:0] OFF_QUEUE_STAT = 8'h1c;
  localparam logic [7:0] OFF_QUEUE_FLAG = 8'h20;
  localparam logic [7:0] OFF_CFG = 8'h24;
  localparam logic [7:0] OFF_START = 8'h28;
  localparam logic [7:0] OFF_TALLY = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  // field positions
  localparam int unsigned RX_FLUSH_BIT = 31;
  localparam int unsigned RXW_LO = 20;
  localparam int unsigned RXW_HI = 21;
  localparam int unsigned ST_TRACK_BIT = 0;
  localparam int unsigned ST_OVR_BIT = 1;
  localparam int unsigned ST_PEND_BIT = 2;
  localparam int unsigned ST_WAIT_BIT = 3;

  // reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] START_RST = 32'h0000_0000;
  localparam logic [31:0] TALLY_RST = 32'h0000_0000;
  localparam logic [1:0] RXW_RST = 2'h2;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // packing slot widths and word size
  localparam logic [5:0] SLOT_UNPACKED = 6'h08;
  localparam logic [5:0] SLOT_PACKED = 6'h04;
  localparam logic [5:0] SMP_BITS_MAG1 = 6'h02;
  localparam logic [5:0] SMP_BITS_MAG3 = 6'h04;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [5:0] POS_ZERO = 6'h00;

  typedef enum logic [1:0] {
    SSC_FMT_UNPACKED = 2'h0,
    SSC_FMT_PACKED = 2'h1,
    SSC_FMT_SUPER = 2'h2,
    SSC_FMT_RSVD = 2'h3
  } ssc_fmt_t;

  // configuration register image, bit 31 downward
  typedef struct packed {
    logic [25:0] rsvd;
    logic track;
    logic invert;
    logic mag3;
    ssc_fmt_t fmt;
    logic enable;
  } ssc_cfg_t;

  // one slave request as the master presents it
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ssc_avmm_req_t;

  // one front-end sample: sign plus up to three magnitude bits
  typedef struct packed {
    logic sign;
    logic [2:0] mag;
  } ssc_sample_t;

endpackage : ssc_pkg

/* File: src/ssc_top.sv */
// navigation sample capture: link sampler, packer, handover countdown and register slave
`timescale 1ns/1ns
`default_nettype none

module ssc_top
(
  input wire logic clk,
  input wire logic rst,
  input wire ssc_pkg::ssc_avmm_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic nav_clk,
  input wire logic nav_sign,
  input wire logic [2:0] nav_mag,
  input wire logic rxq_ready,
  output logic rxq_valid,
  output logic [31:0] rxq_data,
  output logic rxq_flush,
  output logic [1:0] rxq_width,
  output logic spi_rx_blocked,
  output logic track_active
);
  import ssc_pkg::*;

  typedef enum logic [2:0] {
    SSC_ACQ = 3'h1,
    SSC_WAIT = 3'h2,
    SSC_TRACK = 3'h4
  } ssc_state_t;

  // ---- link domain ----
  // capture clock; invert is quasi-static, change it only while capture is off
  wire logic cap_clk;
  ssc_cfg_t cfg_q;
  assign cap_clk = nav_clk ^ cfg_q.invert;

  ssc_sample_t lnk_smp_q;
  logic lnk_tgl_q;

  // one flop per sample; the toggle marks a new sample to the bus domain
  always_ff @(posedge cap_clk or posedge rst)
  begin
    if (rst)
    begin
      lnk_smp_q <= '0;
      lnk_tgl_q <= 1'b0;
    end
    else
    begin
      lnk_smp_q <= '{sign: nav_sign, mag: nav_mag};
      lnk_tgl_q <= ~lnk_tgl_q;
    end
  end

  // ---- crossing into clk ----
  // data and toggle both pass two flops; the edge detector compares a third and fourth
  // toggle stage so data has settled one cycle before it is taken
  ssc_sample_t smp_s1_q, smp_s2_q;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q, tgl_s4_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      smp_s1_q <= '0;
      smp_s2_q <= '0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      tgl_s4_q <= 1'b0;
    end
    else
    begin
      smp_s1_q <= lnk_smp_q;
      smp_s2_q <= smp_s1_q;
      tgl_s1_q <= lnk_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      tgl_s4_q <= tgl_s3_q;
    end
  end

  // ---- register slave decode ----
  wire logic req_any;
  wire logic acc;
  wire logic wr_acc;
  wire logic [31:0] be_mask;
  wire logic hit_stat, hit_flag, hit_cfg, hit_start, hit_tally, hit_status;

  assign req_any = avs_req.read | avs_req.write;
  // access completes in the cycle waitrequest is low
  assign acc = req_any & ~avs_waitrequest;
  assign wr_acc = acc & avs_req.write;
  assign hit_stat = avs_req.address == OFF_QUEUE_STAT;
  assign hit_flag = avs_req.address == OFF_QUEUE_FLAG;
  assign hit_cfg = avs_req.address == OFF_CFG;
  assign hit_start = avs_req.address == OFF_START;
  assign hit_tally = avs_req.address == OFF_TALLY;
  assign hit_status = avs_req.address == OFF_STATUS;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_be
      assign be_mask[gb*8 +: 8] = {8{avs_req.byteenable[gb]}};
    end
  endgenerate

  // ---- registers written by software ----
  logic [31:0] start_q;
  logic [1:0] rxw_q;
  wire ssc_cfg_t cfg_d;
  wire logic [31:0] start_d;
  wire logic [1:0] rxw_d;
  wire logic flush_wr;
  wire logic width_chg;

  assign cfg_d = (cfg_q & ~be_mask) | (avs_req.writedata & be_mask);
  assign start_d = (start_q & ~be_mask) | (avs_req.writedata & be_mask);
  assign rxw_d = avs_req.byteenable[2] ? avs_req.writedata[RXW_HI:RXW_LO] : rxw_q;
  assign flush_wr = wr_acc & hit_stat & avs_req.byteenable[3]
                    & avs_req.writedata[RX_FLUSH_BIT];
  assign width_chg = wr_acc & hit_flag & (rxw_d != rxw_q);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q <= CFG_RST;
      start_q <= START_RST;
      rxw_q <= RXW_RST;
    end
    else
    begin
      if (wr_acc & hit_cfg)
        cfg_q <= cfg_d;
      if (wr_acc & hit_start)
        start_q <= start_d;
      if (wr_acc & hit_flag)
        rxw_q <= rxw_d;
    end
  end

  // ---- sample event and storage decision ----
  logic [31:0] cnt_q;
  logic [31:0] tally_q;
  ssc_state_t st_q;
  wire logic smp_evt;
  wire logic cnt_zero;
  wire logic discard;
  wire logic store;
  wire logic flush_any;

  // samples only count while capture is enabled
  assign smp_evt = (tgl_s3_q ^ tgl_s4_q) & cfg_q.enable;
  assign cnt_zero = cnt_q == RD_ZERO;
  // track request with countdown expired drops data
  assign discard = cfg_q.track & cnt_zero;
  assign store = smp_evt & ~discard;
  assign flush_any = flush_wr | width_chg;

  // ---- tracking state machine ----
  ssc_state_t st_d;
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      SSC_ACQ:
        if (cfg_q.track)
          st_d = cnt_zero ? SSC_TRACK : SSC_WAIT;
      SSC_WAIT:
        if (!cfg_q.track)
          st_d = SSC_ACQ;
        else if (cnt_zero)
          st_d = SSC_TRACK;
      SSC_TRACK:
        if (!cfg_q.track)
          st_d = SSC_ACQ;
      default:
        st_d = SSC_ACQ;
    endcase
  end

  wire logic leave_track;
  wire logic enter_track;
  assign leave_track = (st_q != SSC_ACQ) & ~cfg_q.track;
  assign enter_track = discard & (st_q != SSC_TRACK);

  function automatic logic [31:0] start_d_or_q(input logic wr);
    start_d_or_q = wr ? start_d : start_q;
  endfunction : start_d_or_q

  // countdown: reload on leaving tracking or a start write, else count down
  wire logic [31:0] cnt_d;
  // reload on track release; step per sample, stop at zero
  assign cnt_d = (leave_track | (wr_acc & hit_start)) ? start_d_or_q(wr_acc & hit_start)
               : (smp_evt & ~cnt_zero) ? cnt_q - 32'h0000_0001
               : cnt_q;

  // tally: cleared on entry, counts discarded samples, frozen otherwise
  wire logic [31:0] tally_d;
  // cleared at tracking entry; counts dropped samples
  // holds value once track bit is low
  assign tally_d = enter_track ? (smp_evt ? 32'h0000_0001 : TALLY_RST)
                 : (discard & smp_evt) ? tally_q + 32'h0000_0001
                 : tally_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= SSC_ACQ;
      cnt_q <= START_RST;
      tally_q <= TALLY_RST;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tally_q <= tally_d;
    end
  end

  // ---- packer ----
  // two or four bits per sample; slot per format
  wire logic [5:0] smp_bits;
  wire logic [5:0] slot;
  wire logic [7:0] smp_val;
  wire logic [5:0] pos_nx;
  wire logic word_done;
  logic [5:0] pos_q;
  logic [31:0] word_q;
  wire logic [31:0] word_nx;

  assign smp_bits = cfg_q.mag3 ? SMP_BITS_MAG3 : SMP_BITS_MAG1;
  // sign above magnitude, lsb-first slots; reserved format acts unpacked
  assign slot = (cfg_q.fmt == SSC_FMT_PACKED) ? SLOT_PACKED
              : (cfg_q.fmt == SSC_FMT_SUPER) ? smp_bits
              : SLOT_UNPACKED;
  assign smp_val = cfg_q.mag3 ? {4'h0, smp_s2_q}
                 : {6'h00, smp_s2_q.sign, smp_s2_q.mag[0]};
  assign word_nx = word_q | ({24'h00_0000, smp_val} << pos_q);
  assign pos_nx = pos_q + slot;
  assign word_done = store & (pos_nx == WORD_BITS);

  // partial word is dropped on flush or disable, no stale bits leak out
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos_q <= POS_ZERO;
      word_q <= RD_ZERO;
    end
    else if (flush_any | ~cfg_q.enable)
    begin
      pos_q <= POS_ZERO;
      word_q <= RD_ZERO;
    end
    else if (word_done)
    begin
      pos_q <= POS_ZERO;
      word_q <= RD_ZERO;
    end
    else if (store)
    begin
      pos_q <= pos_nx;
      word_q <= word_nx;
    end
  end

  // ---- queue push ----
  // single holding word; a word finished while the queue still stalls is lost
  logic ovr_q;
  wire logic push_free;
  wire logic ovr_set;
  wire logic ovr_clr;
  assign push_free = ~rxq_valid | rxq_ready;
  assign ovr_set = word_done & ~push_free & ~flush_any;
  assign ovr_clr = wr_acc & hit_status & avs_req.byteenable[0]
                   & avs_req.writedata[ST_OVR_BIT];

  // finished words go to the receive queue
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxq_valid <= 1'b0;
      rxq_data <= RD_ZERO;
    end
    else if (flush_any)
      rxq_valid <= 1'b0;
    else if (word_done & push_free)
    begin
      rxq_valid <= 1'b1;
      rxq_data <= word_nx;
    end
    else if (rxq_ready)
      rxq_valid <= 1'b0;
  end

  // overrun flag: set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ovr_q <= 1'b0;
    else
      ovr_q <= ovr_set | (ovr_q & ~ovr_clr);
  end

  // ---- side outputs ----
  // queue owned by capture while enabled; width to queue
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxq_flush <= 1'b0;
      rxq_width <= RXW_RST;
      spi_rx_blocked <= 1'b0;
      track_active <= 1'b0;
    end
    else
    begin
      rxq_flush <= flush_any;
      rxq_width <= rxw_q;
      spi_rx_blocked <= cfg_q.enable;
      track_active <= st_q == SSC_TRACK;
    end
  end

  // ---- read mux and handshake ----
  wire logic [31:0] status_w;
  wire logic [31:0] flag_w;
  wire logic [31:0] rd_mux;
  assign status_w = RD_ZERO | ({31'h0000_0000, st_q == SSC_TRACK} << ST_TRACK_BIT)
                  | ({31'h0000_0000, ovr_q} << ST_OVR_BIT)
                  | ({31'h0000_0000, rxq_valid} << ST_PEND_BIT)
                  | ({31'h0000_0000, st_q == SSC_WAIT} << ST_WAIT_BIT);
  assign flag_w = {30'h0000_0000, rxw_q} << RXW_LO;
  // tally readable; unmapped and write-only read zero
  assign rd_mux = hit_cfg ? cfg_q
                : hit_start ? start_q
                : hit_tally ? tally_q
                : hit_flag ? flag_w
                : hit_status ? status_w
                : RD_ZERO;

  // one wait cycle for every access, mapped or not
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= RD_ZERO;
    end
    else if (req_any & avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_req.read ? rd_mux : RD_ZERO;
    end
    else
      avs_waitrequest <= 1'b1;
  end

endmodule : ssc_top

`default_nettype wire

/* File: verification/ssc_nav_fe.sv */
// partner: navigation front end with a gated sample clock
`timescale 1ns/1ns
`default_nettype none
module ssc_nav_fe
(
  input wire logic run,
  output logic nav_clk,
  output logic nav_sign,
  output logic [2:0] nav_mag,
  output var int edges
);
  // fixed sample: sign 1, magnitude 3'h2, so a leak of mag[1] shows in 1-bit mode
  assign nav_sign = 1'b1;
  assign nav_mag = 3'h2;
  // stands still low between bursts; odd offset keeps phase unrelated to clk
  initial
  begin
    nav_clk = 1'b0;
    #17;
    forever
    begin
      #80;
      if (run || nav_clk)
        nav_clk = ~nav_clk;
    end
  end
  // rising edges made so far
  always @(posedge nav_clk)
    edges <= edges + 1;
endmodule : ssc_nav_fe
`default_nettype wire

/* File: verification/ssc_top_assertions.sv */
// checker: port timing of the capture block
`timescale 1ns/1ns
`default_nettype none
module ssc_top_assertions
(
  input wire logic clk,
  input wire logic rst,
  input wire ssc_pkg::ssc_avmm_req_t avs_req,
  input wire logic avs_waitrequest,
  input wire logic rxq_ready,
  input wire logic rxq_valid,
  input wire logic [31:0] rxq_data,
  input wire logic rxq_flush,
  input wire logic [1:0] rxq_width,
  input wire logic spi_rx_blocked,
  input wire logic track_active
);
  import ssc_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // accepted writes, decoded by target
  wire logic acc = !avs_waitrequest && avs_req.write;
  wire logic acc_cfg = acc && avs_req.address == OFF_CFG;
  wire logic acc_w = acc && avs_req.address == OFF_QUEUE_FLAG;
  // a flush or width write may legally drop a stalled word
  wire logic acc_qw = acc_w || (acc && avs_req.address == OFF_QUEUE_STAT);
  sequence s_flush_wr;
    acc && avs_req.address == OFF_QUEUE_STAT && avs_req.writedata[31];
  endsequence
  sequence s_stall;
    rxq_valid && !rxq_ready;
  endsequence
  property p_answer;
    (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  // blocking only follows a config write
  property p_blocked;
    $changed(spi_rx_blocked) |-> $past(acc_cfg) || $past(acc_cfg, 2);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked moved");
  property p_hold;
    s_stall ##0 !acc_qw |=> rxq_valid && $stable(rxq_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word not held");
  property p_flush;
    s_flush_wr |-> ##[1:3] rxq_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_pulse;
    rxq_flush |=> !rxq_flush;
  endproperty
  a_pulse: assert property (p_pulse) else $error("flush too long");
  property p_width;
    $changed(rxq_width) |-> $past(rxq_flush);
  endproperty
  a_width: assert property (p_width) else $error("width change unflushed");
  // no new word once tracking has settled
  property p_track;
    track_active && $past(track_active, 2) && !rxq_valid |=> !rxq_valid;
  endproperty
  a_track: assert property (p_track) else $error("word while tracking");
endmodule : ssc_top_assertions
bind ssc_top ssc_top_assertions chk_u (.*);
`default_nettype wire

/* File: verification/ssc_top_tb.sv */
// testbench: packing, handover, tally and register checks
`timescale 1ns/1ns
`default_nettype none
module ssc_top_tb;
  import ssc_pkg::*;
  typedef struct packed { logic [31:0] cfg; logic [31:0] word; } ssc_row_t;
  // cfg image beside the word it gives for sample sign 1, magnitude 3'h2
  localparam ssc_row_t ROWS [7] = '{'{32'h01, 32'h0202_0202}, '{32'h03, 32'h2222_2222},
    '{32'h05, 32'haaaa_aaaa}, '{32'h07, 32'h0202_0202}, '{32'h19, 32'h0a0a_0a0a},
    '{32'h0b, 32'haaaa_aaaa}, '{32'h1d, 32'haaaa_aaaa}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic rxq_ready = 1'b1;
  ssc_avmm_req_t avs_req = '0;
  logic [31:0] avs_readdata, rxq_data, q, last;
  logic avs_waitrequest, rxq_valid, rxq_flush, spi_rx_blocked, track_active;
  logic [1:0] rxq_width;
  wire logic nav_clk, nav_sign;
  wire logic [2:0] nav_mag;
  int edges, fail_count, checked, words, flushes, n;
  ssc_top dut_u (.*);
  ssc_nav_fe fe_u (.*);
  // bus clock
  always #20 clk = ~clk;
  // words taken by the queue and flush pulses
  always @(posedge clk)
  begin
    if ((rxq_valid && rxq_ready) === 1'b1)
    begin
      words++;
      last <= rxq_data;
    end
    if (rxq_flush === 1'b1)
      flushes++;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : cmp
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: d};
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req <= '0;
  endtask : bus
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    cmp(q, e, s);
  endtask : chk
  // mode bits change only while capture is off
  task automatic cfgw(input logic [31:0] d);
    bus(1'b1, OFF_CFG, d & 32'hfffe);
    // a flipped invert bit can make a capture edge; let it drain while disabled
    repeat (8) @(posedge clk);
    bus(1'b1, OFF_CFG, d);
  endtask : cfgw
  // exactly k sample edges, then time for the synchroniser
  task automatic burst(input int k);
    int e;
    e = edges + k;
    run <= 1'b1;
    while (edges < e)
      @(posedge clk);
    run <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : burst
  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i])
    begin
      cfgw(ROWS[i].cfg);
      last = 'x;
      burst(20);
      cmp(last, ROWS[i].word, "word");
      cmp(spi_rx_blocked, 1'b1, "reserved");
    end
    done("formats");
    // queue stalls: word must wait
    rxq_ready <= 1'b0;
    cfgw(32'h01);
    burst(8);
    cmp(rxq_valid, 1'b1, "held");
    last = 'x;
    rxq_ready <= 1'b1;
    repeat (2) @(posedge clk);
    cmp(last, 32'h0202_0202, "stalled word");
    // second word finished under the stall was dropped and flagged
    chk(OFF_STATUS, 32'h2, "overrun");
    bus(1'b1, OFF_STATUS, 32'h2);
    chk(OFF_STATUS, RD_ZERO, "overrun cleared");
    done("stall");
    // start equals a chunk of two words
    bus(1'b1, OFF_START, 32'h8);
    cfgw(32'h21);
    n = words;
    burst(20);
    cmp(words - n, 2, "words");
    cmp(track_active, 1'b1, "tracking");
    chk(OFF_TALLY, 12, "tally");
    bus(1'b1, OFF_CFG, 32'h01);
    n = words;
    burst(4);
    cmp(words - n, 1, "resumed");
    chk(OFF_TALLY, 12, "frozen");
    bus(1'b1, OFF_CFG, 32'h21);
    chk(OFF_STATUS, 32'h8, "waiting");
    n = words;
    burst(10);
    cmp(words - n, 1, "reloaded");
    chk(OFF_TALLY, 6, "restarted");
    done("tracking");
    bus(1'b1, OFF_START, 32'h1234_abcd);
    chk(OFF_START, 32'h1234_abcd, "start");
    bus(1'b1, OFF_TALLY, 32'h5a);
    chk(OFF_TALLY, 6, "read only");
    chk(8'h40, RD_ZERO, "unmapped");
    n = flushes;
    bus(1'b1, OFF_QUEUE_STAT, 32'h8000_0000);
    bus(1'b1, OFF_QUEUE_FLAG, 32'h0010_0000);
    repeat (4) @(posedge clk);
    cmp(flushes - n, 2, "flushes");
    cmp(rxq_width, 2'h1, "width");
    done("registers");
    // reset in mid-run with tracking on
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cmp({track_active, spi_rx_blocked}, 2'h0, "flags reset");
    chk(OFF_CFG, CFG_RST, "cfg reset");
    chk(OFF_START, START_RST, "start reset");
    chk(OFF_TALLY, TALLY_RST, "tally reset");
    chk(OFF_QUEUE_FLAG, {10'h0, RXW_RST, 20'h0}, "width reset");
    done("reset");
    results();
  end
  // tests take about 45 us; a hang is cut well after
  initial
  begin
    #400000;
    fail_count++;
    $display("mismatch at %0t: watchdog", $time);
    results();
  end
endmodule : ssc_top_tb
`default_nettype wire
